// file: spg_params.svh
// Offsets, field positions, reset values and timing counts for the guard
`ifndef SPG_PARAMS_SVH
`define SPG_PARAMS_SVH

`define SPG_ADDR_W        17
`define SPG_PAGE_W        10
`define SPG_DATA_W        32

// Register word byte addresses on the slave bus
`define SPG_OFF_CTRL      4'h0
`define SPG_OFF_LOCK      4'h4
`define SPG_OFF_FUSE      4'h8
`define SPG_OFF_STAT      4'hc

// Control register fields
`define SPG_CMD_LSB       0
`define SPG_CMD_W         7
`define SPG_CMD_ERASE     7'h03
`define SPG_CMD_WRITE     7'h05
`define SPG_CMD_LOAD      7'h01
`define SPG_CMD_CLRBUSY   7'h11
`define SPG_CMD_LOCKSET   7'h09

// Lock register fields, 1 means unprogrammed
`define SPG_LOCK_APP_LO   0
`define SPG_LOCK_APP_HI   1
`define SPG_LOCK_BOOT_LO  2
`define SPG_LOCK_BOOT_HI  3
`define SPG_LOCK_RESET    4'hf

// Fuse register: boot size code and vector placement
`define SPG_FUSE_RESET    2'h0
`define SPG_IVSEL_BIT     2

// Status bits
`define SPG_ST_BUSY       0
`define SPG_ST_ACTIVE     1
`define SPG_ST_REFUSED    2

// Arm window after the command write, in instruction cycles
`define SPG_ARM_CYCLES    3'h4

// Fixed concurrent / non-concurrent boundary as a word address
`define SPG_NONCONCURRENT_REGION_START    17'h1f000

// Page operation time and derived cycle count at 100 MHz
`define SPG_PROG_TIME_US  4500
`define SPG_CLK_MHZ       100
`define SPG_PROG_CYCLES   (`SPG_PROG_TIME_US * `SPG_CLK_MHZ)

`endif

// file: spg_pkg.sv
// Types shared by the self-programming section guard
package spg_pkg;

  typedef struct packed {
    logic        store_req;
    logic        load_req;
    logic [16:0] pc;
    logic [16:0] target;
  } spg_op_type;

  typedef struct packed {
    logic stall;
    logic fetch_block;
    logic irq_mask;
    logic load_deny;
  } spg_gate_type;

  typedef enum logic [2:0] {
    SPG_IDLE = 3'b001,
    SPG_RWW  = 3'b010,
    SPG_HALT = 3'b100
  } spg_state_type;

endpackage

// file: spg_guard.sv
// Self-programming section guard with Avalon-MM control registers
// What this block does
// - Programming starts only from boot region code
// - Boot code may target any flash page
// - Concurrent-region programming keeps core running
// - Non-concurrent programming halts the core
// - Boot region always inside non-concurrent region
// - Busy flag high while concurrent region blocked
// - Busy flag sticks until software clears
// - Boot size fuse sets boot boundary only
// - Boot locks only programmed; chip erase restores
// - General lock modes ignore self-programming
// - App locks unprogrammed: no app restriction
// - Lower app lock blocks stores to app
// - Upper app lock blocks boot loads of app
// - Upper app lock masks irqs in app when vectors in boot
// - Boot locks unprogrammed: no boot restriction
// - Lower boot lock blocks stores to boot
// - Upper boot lock blocks app loads of boot
// - Upper boot lock masks irqs in boot when vectors in app
// - Store must follow command within four cycles
`timescale 1ns/1ps
`include "spg_params.svh"
`default_nettype none

module spg_guard #(
  parameter int unsigned PROG_CYCLES = `SPG_PROG_CYCLES
) (
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_n,
  input  wire logic [3:0]             i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  output logic      [31:0]            o_avs_readdata,
  output logic                        o_avs_waitrequest,
  input  wire spg_pkg::spg_op_type    i_op,
  input  wire logic                   i_core_step,
  input  wire logic                   i_chip_erase,
  input  wire logic [1:0]             i_general_lock,
  output spg_pkg::spg_gate_type       o_gate,
  output logic                        o_prog_start,
  output logic                        o_region_busy_flag
);

  typedef logic [16:0] spg_addr_type;

  // Boot region start for a boot size fuse code; four sizes.
  function automatic spg_addr_type boot_start(input logic [1:0] code);
    case (code)
      2'h0:    boot_start = 17'h1f000;
      2'h1:    boot_start = 17'h1f800;
      2'h2:    boot_start = 17'h1fc00;
      default: boot_start = 17'h1fe00;
    endcase
  endfunction

  function automatic logic in_boot(input spg_addr_type a,
                                   input logic [1:0] code);
    in_boot = (a >= boot_start(code));
  endfunction

  logic [`SPG_CMD_W-1:0]  cmd_q,  cmd_d;
  logic [2:0]             arm_q,  arm_d;
  logic [3:0]             lock_q, lock_d;
  logic [2:0]             fuse_q, fuse_d;
  logic                   busy_q, busy_d;
  logic                   refused_q, refused_d;
  logic [31:0]            cnt_q,  cnt_d;
  logic [31:0]            rdata_q;
  logic                   wait_q;
  logic                   start_q;
  spg_pkg::spg_state_type state_q, state_d;
  spg_pkg::spg_gate_type  gate_q, gate_d;

  // Bus decode
  wire logic bus_req     = i_avs_read | i_avs_write;
  wire logic bus_take    = bus_req & ~wait_q;
  wire logic wr_ctrl     = bus_take & i_avs_write &
                           (i_avs_address == `SPG_OFF_CTRL);
  wire logic wr_fuse     = bus_take & i_avs_write &
                           (i_avs_address == `SPG_OFF_FUSE);

  // Region classification of executing code and target
  wire logic [1:0] bsz   = fuse_q[1:0];
  wire logic pc_boot     = in_boot(i_op.pc, bsz);
  wire logic tgt_boot    = in_boot(i_op.target, bsz);
  // Concurrent boundary is fixed, boot start never below it
  wire logic tgt_nonconcurrent_region    = (i_op.target >= `SPG_NONCONCURRENT_REGION_START);
  wire logic ivec_boot   = fuse_q[`SPG_IVSEL_BIT];

  wire logic app_lo      = lock_q[`SPG_LOCK_APP_LO];
  wire logic app_hi      = lock_q[`SPG_LOCK_APP_HI];
  wire logic boot_lo     = lock_q[`SPG_LOCK_BOOT_LO];
  wire logic boot_hi     = lock_q[`SPG_LOCK_BOOT_HI];

  // General lock modes are not consulted here
  wire logic general_unused = ^i_general_lock;

  // Store permission: app lower lock / boot lower lock
  wire logic store_lock_ok = tgt_boot ? boot_lo
                                      : app_lo;
  wire logic cmd_page    = (cmd_q == `SPG_CMD_ERASE) |
                           (cmd_q == `SPG_CMD_WRITE);
  wire logic cmd_armed   = (arm_q != 3'h0);
  // Lower locks guard flash pages, not lock or flag commands
  wire logic store_ok    = i_op.store_req & cmd_armed & pc_boot &
                           (~cmd_page | store_lock_ok) &
                           (state_q == spg_pkg::SPG_IDLE);
  wire logic prog_go     = store_ok & cmd_page;
  wire logic store_bad   = i_op.store_req & ~store_ok;
  wire logic lock_go     = store_ok & (cmd_q == `SPG_CMD_LOCKSET);
  wire logic clr_go      = store_ok & (cmd_q == `SPG_CMD_CLRBUSY);

  // Load permission across regions
  wire logic load_deny   = i_op.load_req &
                           ((pc_boot & ~tgt_boot & ~app_hi) |
                            (~pc_boot & tgt_boot & ~boot_hi));

  // Interrupt masking by upper locks
  wire logic irq_mask    = (~app_hi & ivec_boot & ~pc_boot) |
                           (~boot_hi & ~ivec_boot & pc_boot);
  // Unprogrammed locks give no restriction on either path

  wire logic prog_done   = (state_q != spg_pkg::SPG_IDLE) &
                           (cnt_q == 32'h0);

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    busy_d    = busy_q;
    cmd_d     = cmd_q;
    arm_d     = arm_q;
    lock_d    = lock_q;
    fuse_d    = fuse_q;
    refused_d = refused_q;
    if (arm_q != 3'h0 && i_core_step) begin
      arm_d = arm_q - 3'h1;
    end
    if (wr_ctrl) begin
      cmd_d = i_avs_writedata[`SPG_CMD_LSB +: `SPG_CMD_W];
      arm_d = `SPG_ARM_CYCLES;
      if (i_avs_writedata[31]) begin
        refused_d = 1'b0;
      end
    end
    if (wr_fuse) begin
      fuse_d = i_avs_writedata[2:0];
    end
    if (store_bad) begin
      refused_d = 1'b1;
    end
    if (lock_go) begin
      // Bits may only go from 1 to 0
      lock_d = lock_q & i_op.target[3:0];
      arm_d  = 3'h0;
    end
    if (clr_go) begin
      if (state_q == spg_pkg::SPG_IDLE) begin
        busy_d = 1'b0;
      end
      arm_d = 3'h0;
    end
    if (i_chip_erase) begin
      lock_d = `SPG_LOCK_RESET;
    end
    case (state_q)
      spg_pkg::SPG_IDLE: begin
        if (prog_go) begin
          cnt_d = PROG_CYCLES - 1;
          arm_d = 3'h0;
          if (tgt_nonconcurrent_region) begin
            state_d = spg_pkg::SPG_HALT;
          end else begin
            state_d = spg_pkg::SPG_RWW;
            busy_d  = 1'b1;
          end
        end
      end
      spg_pkg::SPG_RWW, spg_pkg::SPG_HALT: begin
        if (prog_done) begin
          state_d = spg_pkg::SPG_IDLE;   // busy keeps its value
        end else begin
          cnt_d = cnt_q - 32'h1;
        end
      end
      default: begin
        state_d = spg_pkg::SPG_IDLE;
      end
    endcase
  end

  always_comb begin
    gate_d.stall       = (state_d == spg_pkg::SPG_HALT);
    // Core obeys this only by convention; fetch is flagged
    gate_d.fetch_block = busy_d;
    gate_d.irq_mask    = irq_mask | (state_d == spg_pkg::SPG_HALT);
    gate_d.load_deny   = load_deny | general_unused & 1'b0;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q   <= spg_pkg::SPG_IDLE;
      cnt_q     <= 32'h0;
      busy_q    <= 1'b0;
      cmd_q     <= 7'h00;
      arm_q     <= 3'h0;
      lock_q    <= `SPG_LOCK_RESET;
      fuse_q    <= 3'h0;
      refused_q <= 1'b0;
      gate_q    <= '0;
      start_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      busy_q    <= busy_d;
      cmd_q     <= cmd_d;
      arm_q     <= arm_d;
      lock_q    <= lock_d;
      fuse_q    <= fuse_d;
      refused_q <= refused_d;
      gate_q    <= gate_d;
      start_q   <= prog_go;
    end
  end

  // One wait cycle per access; data returns when waitrequest drops
  wire logic [31:0] rd_mux =
    (i_avs_address == `SPG_OFF_CTRL) ? {25'h0, cmd_q} :
    (i_avs_address == `SPG_OFF_LOCK) ? {28'h0, lock_q} :
    (i_avs_address == `SPG_OFF_FUSE) ? {29'h0, fuse_q} :
    (i_avs_address == `SPG_OFF_STAT) ?
      {29'h0, refused_q, (state_q != spg_pkg::SPG_IDLE), busy_q} :
      32'h0;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q  <= ~(bus_req & wait_q);
      rdata_q <= (bus_req & wait_q) ? rd_mux : rdata_q;
    end
  end

  assign o_avs_readdata     = rdata_q;
  assign o_avs_waitrequest  = wait_q;
  assign o_gate             = gate_q;
  assign o_prog_start       = start_q;
  assign o_region_busy_flag = busy_q;

endmodule // spg_guard

`default_nettype wire

// file: spg_guard_assertions.sv
// Port-level checks for the section guard
`timescale 1ns/1ps
`include "spg_params.svh"
`default_nettype none
module spg_guard_sva #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic                  i_mclk,
  input wire logic                  i_rst_n,
  input wire logic                  i_avs_read,
  input wire logic                  i_avs_write,
  input wire logic                  o_avs_waitrequest,
  input wire spg_pkg::spg_op_type   i_op,
  input wire spg_pkg::spg_gate_type o_gate,
  input wire logic                  o_prog_start,
  input wire logic                  o_region_busy_flag
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  int unsigned stall_len;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stall_len <= 0;
    end else begin
      stall_len <= o_gate.stall ? stall_len + 1 : 0;
    end
  end
  bus_answer_a: assert property (
    (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus answer late");
  app_no_start_a: assert property (
    i_op.store_req && i_op.pc < `SPG_NONCONCURRENT_REGION_START |=> !o_prog_start)
    else $error("store from application started");
  start_gate_a: assert property (
    o_prog_start |-> o_region_busy_flag || o_gate.stall)
    else $error("start without busy or halt");
  rww_runs_a: assert property (
    $rose(o_region_busy_flag) |-> !o_gate.stall && o_gate.fetch_block)
    else $error("concurrent programming halted core");
  halt_hold_a: assert property (
    $rose(o_gate.stall) |-> o_gate.stall [*8])
    else $error("halt dropped early");
  halt_len_a: assert property (
    $fell(o_gate.stall) |->
      stall_len + 1 >= PROG_CYCLES && stall_len <= PROG_CYCLES + 1)
    else $error("halt length wrong");
  busy_sticky_a: assert property (
    o_region_busy_flag && !i_op.store_req |=> o_region_busy_flag)
    else $error("busy cleared without store");
  halt_irq_a: assert property (
    o_gate.stall |-> o_gate.irq_mask)
    else $error("irq open while halted");
  one_start_a: assert property (
    o_prog_start |=> !o_prog_start [*8])
    else $error("second start during operation");
endmodule // spg_guard_sva
bind spg_guard spg_guard_sva #(.PROG_CYCLES(PROG_CYCLES)) u_sva (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
  .i_op(i_op), .o_gate(o_gate), .o_prog_start(o_prog_start),
  .o_region_busy_flag(o_region_busy_flag));
`default_nettype wire

// file: spg_core_model.sv
// Processor core stand-in issuing program memory operations
`timescale 1ns/1ps
`include "spg_params.svh"
`default_nettype none
module spg_core_model (
  input  wire logic                  i_mclk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_go,
  input  wire spg_pkg::spg_op_type   i_req,
  input  wire spg_pkg::spg_gate_type i_gate,
  output spg_pkg::spg_op_type        o_op,
  output logic                       o_core_step
);
  // Software never touches the blocked region
  wire logic unsafe = i_gate.fetch_block && i_req.pc < `SPG_NONCONCURRENT_REGION_START;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_op        <= '0;
      o_core_step <= 1'b0;
    end else begin
      o_core_step <= !i_gate.stall;
      // Idle address lines keep toggling so stale values never match
      o_op <= (i_go && !i_gate.stall && !unsafe) ? i_req
            : {2'b00, ~o_op.pc, ~o_op.target};
    end
  end
endmodule // spg_core_model
`default_nettype wire

// file: tb_top.sv
// Self-checking bench for the section guard
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [16:0] pc;
    logic [16:0] tgt;
    logic [3:0]  exp;
  } spg_row_type;
  localparam int PROG = 20;
  // exp holds start, busy, halt, refused
  localparam spg_row_type ROWS [6] = '{
    '{8'h03, 17'h1f100, 17'h00100, 4'hc},
    '{8'h05, 17'h00100, 17'h00200, 4'h1},
    '{8'h85, 17'h1f100, 17'h1f400, 4'ha},
    '{8'h01, 17'h1f100, 17'h00100, 4'h0},
    '{8'h00, 17'h1f100, 17'h00100, 4'h0},
    '{8'h83, 17'h1ff00, 17'h1ff80, 4'ha}};
  logic                  clk;
  logic                  rst_n = 1'b0;
  logic                  rd = 1'b0;
  logic                  wr = 1'b0;
  logic                  go = 1'b0;
  logic                  ce = 1'b0;
  logic [3:0]            addr = 4'h0;
  logic [31:0]           wdata = 32'h0;
  logic [31:0]           rdata, q;
  logic                  wreq, start, busy, step;
  spg_pkg::spg_op_type   req = '0;
  spg_pkg::spg_op_type   op;
  spg_pkg::spg_gate_type gate;
  int                    failures, cmp_count, cyc, n_start;
  logic                  saw_busy, saw_stall, saw_deny, saw_irq;
  // General locks tied fully programmed: they must not matter
  spg_guard #(.PROG_CYCLES(PROG)) uut (.i_mclk(clk), .i_rst_n(rst_n),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_op(op), .i_core_step(step),
    .i_chip_erase(ce), .i_general_lock(2'h0), .o_gate(gate),
    .o_prog_start(start), .o_region_busy_flag(busy));
  spg_core_model core (.i_mclk(clk), .i_rst_n(rst_n), .i_go(go),
    .i_req(req), .i_gate(gate), .o_op(op), .o_core_step(step));
  task automatic give_verdict;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic do_op(input logic [31:0] c, input logic [16:0] p,
                       input logic [16:0] t, input logic ld, input int gap);
    bus(1'b1, 4'h0, c);
    repeat (gap) @(posedge clk);
    req <= '{~ld, ld, p, t};
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (PROG + 10) @(posedge clk);
  endtask
  task automatic clr;
    do_op(32'h8000_0011, 17'h1f100, 17'h0, 1'b0, 0);
    n_start   = 0;
    saw_busy  = 1'b0;
    saw_stall = 1'b0;
    saw_deny  = 1'b0;
    saw_irq   = 1'b0;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (start === 1'b1) n_start++;
    if (busy === 1'b1) saw_busy = 1'b1;
    if (gate.stall === 1'b1) saw_stall = 1'b1;
    if (gate.load_deny === 1'b1) saw_deny = 1'b1;
    if (gate.irq_mask === 1'b1) saw_irq = 1'b1;
    if (cyc == 8000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h4, 32'h0);
    check(q, 32'hf);
    bus(1'b0, 4'h6, 32'h0);
    check(q, 32'h0);
    foreach (ROWS[i]) begin
      clr;
      do_op({24'h0, ROWS[i].cmd}, ROWS[i].pc, ROWS[i].tgt, 1'b0, 0);
      check(n_start, ROWS[i].exp[3]);
      check(saw_busy, ROWS[i].exp[2]);
      check(busy, ROWS[i].exp[2]);
      check(saw_stall, ROWS[i].exp[1]);
      bus(1'b0, 4'hc, 32'h0);
      check(q[2], ROWS[i].exp[0]);
    end
    clr;
    check(busy, 1'b0);
    // Store arriving after the arm window has run out
    do_op(32'h3, 17'h1f100, 17'h00100, 1'b0, 6);
    check(n_start, 0);
    do_op(32'h9, 17'h1f100, 17'h0000e, 1'b0, 0);
    clr;
    do_op(32'h3, 17'h1f100, 17'h00100, 1'b0, 0);
    check(n_start, 0);
    do_op(32'h9, 17'h1f100, 17'h00007, 1'b0, 0);
    bus(1'b0, 4'h4, 32'h0);
    check(q[3:0], 4'h6);
    clr;
    do_op(32'h0, 17'h00100, 17'h1f800, 1'b1, 0);
    check(saw_deny, 1'b1);
    ce <= 1'b1;
    @(posedge clk);
    ce <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    check(q[3:0], 4'hf);
    clr;
    do_op(32'h0, 17'h00100, 17'h1f800, 1'b1, 0);
    check(saw_deny, 1'b0);
    bus(1'b1, 4'h8, 32'h4);
    do_op(32'h9, 17'h1f100, 17'h0000d, 1'b0, 0);
    clr;
    do_op(32'h0, 17'h00100, 17'h00200, 1'b1, 0);
    check(saw_irq, 1'b1);
    bus(1'b1, 4'h8, 32'h3);
    clr;
    do_op(32'h3, 17'h1f100, 17'h00100, 1'b0, 0);
    check(n_start, 0);
    do_op(32'h3, 17'h1ff00, 17'h00100, 1'b0, 0);
    check(n_start, 1);
    check(busy, 1'b1);
    // Mid-run reset drops the sticky flag and the fuse copy
    rst_n <= 1'b0;
    @(posedge clk);
    check(busy, 1'b0);
    check(wreq, 1'b1);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h8, 32'h0);
    check(q, 32'h0);
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire
